// file: ict_timer.sv
// instruction cycle timer: takes one instruction's tabulated base timing,
// applies every correction, then paces the microcode cycles on the core clock
// assumes the requester holds req stable only for the accepting cycle
`timescale 1ns/10ps
`include "ict_map.svh"

module ict_timer
  import ict_pkg::*;
(
  input  logic     core_clk,
  input  logic     rstn,
  input  logic     req_valid,
  input  ict_req_t req,
  output logic     req_ready,
  output logic     busy,
  output logic     ucyc_tick,
  output logic     done,
  output ict_res_t res
);

  localparam logic [6:0] DIV_LAST = 7'(`ICT_CLKS_PER_UCYC - 1);
  localparam logic [17:0] UCYC_NS = 18'(`ICT_UCYC_NS);

  // ==========================================================
  // state
  ict_state_t        state_q, state_d;
  ict_req_t          req_q, req_d;
  ict_res_t          res_q, res_d;
  logic [6:0]        div_q, div_d;
  logic [8:0]        ucyc_q, ucyc_d;
  logic signed [7:0] delta_cyc;
  logic signed [2:0] delta_rd;
  logic [2:0]        dst_rd;
  logic              split_rd;
  logic signed [9:0] tot_cyc;
  logic signed [5:0] tot_rd;

  ict_adjust u_adjust (
    .req       (req_q),
    .delta_cyc (delta_cyc),
    .delta_rd  (delta_rd),
    .dst_rd    (dst_rd),
    .split_rd  (split_rd)
  );

  // ==========================================================
  // totals
  // base and corrections simply add; a total below zero cannot occur for a
  // legal instruction, but is held at zero rather than wrapping
  always_comb begin
    tot_cyc = $signed({2'h0, req_q.base_cyc}) + 10'(delta_cyc);  // RULE16
    tot_rd  = $signed({2'h0, req_q.base_rd}) + 6'(delta_rd);
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_d   = state_q;
    req_d     = req_q;
    res_d     = res_q;
    div_d     = div_q;
    ucyc_d    = ucyc_q;
    ucyc_tick = 1'b0;
    case (state_q)
      ICT_S_IDLE: begin
        if (req_valid) begin
          req_d   = req;
          state_d = ICT_S_CALC;
        end
      end
      ICT_S_CALC: begin
        res_d.cycles     = tot_cyc[9] ? 9'h000 : tot_cyc[8:0];
        res_d.reads      = tot_rd[5] ? 4'h0 : tot_rd[3:0];
        res_d.time_ns    = 18'(res_d.cycles) * UCYC_NS;  // RULE1
        res_d.dst_reads  = dst_rd;
        res_d.split_read = split_rd;
        div_d            = 7'h00;
        ucyc_d           = 9'h000;
        state_d          = (res_d.cycles == 9'h000) ? ICT_S_DONE : ICT_S_RUN;
      end
      ICT_S_RUN: begin
        // one microcode cycle lasts a whole number of core clocks, rounded up
        if (div_q == DIV_LAST) begin  // RULE1
          ucyc_tick = 1'b1;
          div_d     = 7'h00;
          ucyc_d    = ucyc_q + 9'h001;
          if (ucyc_q + 9'h001 == res_q.cycles) begin
            state_d = ICT_S_DONE;
          end
        end else begin
          div_d = div_q + 7'h01;
        end
      end
      ICT_S_DONE: begin
        state_d = ICT_S_IDLE;
      end
      default: begin
        state_d = ICT_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ICT_S_IDLE;
      req_q   <= '0;
      res_q   <= '0;
      div_q   <= 7'h00;
      ucyc_q  <= 9'h000;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      res_q   <= res_d;
      div_q   <= div_d;
      ucyc_q  <= ucyc_d;
    end
  end

  assign req_ready = (state_q == ICT_S_IDLE);
  assign busy      = (state_q != ICT_S_IDLE);
  assign done      = (state_q == ICT_S_DONE);
  assign res       = res_q;

  // ==========================================================
  // assertions
  // checks of corrections are sampled in the calc state, where req_q is stable
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic calc;
  assign calc = (state_q == ICT_S_CALC);

  // ==========================================================
  // pacing monitor
  // counted apart from the divider, so the period checks do not lean on
  // the very counter that they guard
  logic [6:0] gap_q, gap_d;

  always_comb begin
    gap_d = gap_q + 7'h01;
    if ((state_q != ICT_S_RUN) || ucyc_tick) begin
      gap_d = 7'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gap_q <= 7'h00;
    end else begin
      gap_q <= gap_d;
    end
  end

  ucyc_period_a: assert property ( // RULE1
    ucyc_tick |-> gap_q == DIV_LAST)
    else $error("microcode cycle is not 67 core clocks");

  ucyc_due_a: assert property ( // RULE1
    (state_q == ICT_S_RUN && gap_q == DIV_LAST) |-> ucyc_tick)
    else $error("microcode cycle overran 67 core clocks");

  tick_in_run_a: assert property ( // RULE1
    ucyc_tick |-> state_q == ICT_S_RUN)
    else $error("microcode tick outside the run state");

  run_entry_a: assert property ( // RULE1
    (calc && !tot_cyc[9] && tot_cyc != 10'sh000)
    |=> state_q == ICT_S_RUN && div_q == 7'h00 && ucyc_q == 9'h000)
    else $error("run state not entered from a clear divider");

  time_scale_a: assert property ( // RULE1
    done |-> res.time_ns == 18'(res.cycles) * 18'd267)
    else $error("time is not cycles times 267 ns");

  pc_autodec_a: assert property ( // RULE2
    (calc && req_q.op == ICT_OP_OTHER && req_q.dst_kind == ICT_DST_NONE &&
     req_q.src_mr == 6'h27 && req_q.dst_mr == 6'h27)
    |-> delta_cyc == 8'shFE && delta_rd == 3'sh7)
    else $error("autodecrement PC saving missing");

  dst_pc07_a: assert property ( // RULE3
    (calc && req_q.op == ICT_OP_OTHER && req_q.dst_kind == ICT_DST_WO &&
     (req_q.dst_mr == 6'h07 || req_q.dst_mr == 6'h0F))
    |-> delta_cyc == 8'shFE && delta_rd == 3'sh7)
    else $error("mode 07/17 destination saving missing");

  m47_reads_a: assert property ( // RULE4
    (calc && req_q.dst_kind == ICT_DST_RO && req_q.dst_mr == 6'h27)
    |=> res.dst_reads == 3'h3 && res.split_read)
    else $error("mode 47 destination read count wrong");

  m57_reads_a: assert property ( // RULE5
    (calc && req_q.dst_kind == ICT_DST_RMW && req_q.dst_mr == 6'h2F)
    |=> res.dst_reads == 3'h4 && res.split_read)
    else $error("mode 57 destination read count wrong");

  call_save_a: assert property ( // RULE6
    (calc && req_q.op == ICT_OP_SUBROUTINE_CALL && req_q.link_is_pc &&
     req_q.dst_kind == ICT_DST_NONE && req_q.src_mr != 6'h27)
    |-> delta_cyc == 8'shFF)
    else $error("subroutine call with PC link not one cycle faster");

  neg_src_a: assert property ( // RULE7
    (calc && req_q.op == ICT_OP_MUL && req_q.src_val[15] && req_q.dst_mr[2:0] != 3'h7 &&
     req_q.dst_kind == ICT_DST_NONE && req_q.src_mr != 6'h27)
    |-> delta_cyc == 8'sh01)
    else $error("negative source cycle missing");

  div_srcmode_a: assert property ( // RULE8
    (calc && req_q.op == ICT_OP_DIV && req_q.src_mr[5:3] != 3'h0 && !req_q.quot_even &&
     !req_q.overflow && req_q.dst_mr[2:0] != 3'h7 && req_q.dst_kind == ICT_DST_NONE &&
     req_q.src_mr != 6'h27)
    |-> delta_cyc == 8'shFF)
    else $error("nonzero source mode saving missing");

  div_even_ovf_a: assert property ( // RULE9
    (calc && req_q.op == ICT_OP_DIV && req_q.src_mr[5:3] == 3'h0 && req_q.quot_even &&
     req_q.overflow && req_q.dst_mr[2:0] != 3'h7 && req_q.dst_kind == ICT_DST_NONE)
    |-> delta_cyc == 8'sh03)
    else $error("even quotient plus overflow not three cycles");

  div_ovf_a: assert property ( // RULE10
    (calc && req_q.op == ICT_OP_DIV && req_q.src_mr[5:3] == 3'h0 && !req_q.quot_even &&
     req_q.overflow && req_q.dst_mr[2:0] != 3'h7 && req_q.dst_kind == ICT_DST_NONE)
    |-> delta_cyc == 8'sh02)
    else $error("division overflow not two cycles");

  div_pc_a: assert property ( // RULE11
    (calc && req_q.op == ICT_OP_DIV && req_q.src_mr == 6'h00 && !req_q.quot_even &&
     !req_q.overflow && req_q.dst_mr[2:0] == 3'h7 && req_q.dst_kind == ICT_DST_NONE)
    |-> delta_cyc == 8'sh05 && delta_rd == 3'sh1)
    else $error("division to PC penalty wrong");

  shift_cnt_a: assert property ( // RULE12
    (calc && req_q.op == ICT_OP_ASH && req_q.dst_mr[2:0] != 3'h7 &&
     req_q.dst_kind == ICT_DST_NONE && req_q.src_mr != 6'h27)
    |-> delta_cyc == $signed({2'h0, req_q.shift_cnt}))
    else $error("shift cycles not one per position");

  ashc_hi_a: assert property ( // RULE13
    (calc && req_q.op == ICT_OP_ASHC && req_q.shift_left && req_q.src_val[15:6] != 10'h000 &&
     req_q.dst_mr[2:0] != 3'h7 && req_q.dst_kind == ICT_DST_NONE && req_q.src_mr != 6'h27)
    |-> delta_cyc == $signed({2'h0, req_q.shift_cnt}) + 8'sh01)
    else $error("combined left shift high-bits cycle missing");

  ashc_one_a: assert property ( // RULE14
    (calc && req_q.op == ICT_OP_ASHC && !req_q.shift_left && req_q.shift_cnt == 6'h01 &&
     req_q.dst_mr[2:0] != 3'h7 && req_q.dst_kind == ICT_DST_NONE && req_q.src_mr != 6'h27)
    |-> delta_cyc == 8'sh00)
    else $error("single right shift saving missing");

  mul_pc_a: assert property ( // RULE15
    (calc && req_q.op == ICT_OP_MUL && !req_q.src_val[15] && req_q.src_mr == 6'h00 &&
     req_q.dst_mr[2:0] == 3'h7 && req_q.dst_kind == ICT_DST_NONE)
    |-> delta_cyc == 8'sh04 && delta_rd == 3'sh1)
    else $error("multiply to PC penalty wrong");

  run_len_a: assert property ( // RULE16
    done |-> ucyc_q == res.cycles)
    else $error("paced microcode cycles differ from total");

  ucyc_bound_a: assert property ( // RULE16
    (state_q == ICT_S_RUN) |-> ucyc_q < res.cycles)
    else $error("paced cycles ran past the total");

  clamp_cyc_a: assert property ( // RULE16
    (calc && tot_cyc[9]) |=> done && res.cycles == 9'h000)
    else $error("negative cycle total not held at zero");

  clamp_rd_a: assert property ( // RULE16
    (calc && tot_rd[5]) |=> res.reads == 4'h0)
    else $error("negative read total not held at zero");

  accept_calc_a: assert property ( // RULE16
    (req_valid && req_ready)
    |=> state_q == ICT_S_CALC && req_q == $past(req))
    else $error("accepted descriptor not captured");

  stray_drop_a: assert property ( // RULE16
    busy |=> req_q == $past(req_q))
    else $error("descriptor changed while busy");

  res_hold_a: assert property ( // RULE16
    (state_q == ICT_S_RUN) |=> $stable(res))
    else $error("result changed while pacing");

  done_pulse_a: assert property ( // RULE16
    done |=> !done && req_ready && !busy)
    else $error("done not a single cycle before idle");

  calc_once_a: assert property ( // RULE16
    calc |=> !calc && busy)
    else $error("calculation state held for more than one cycle");

  idle_quiet_a: assert property ( // RULE1
    req_ready |-> !ucyc_tick && !done)
    else $error("tick or done raised while idle");

  split_flag_a: assert property ( // RULE4
    done |-> res.split_read == (res.dst_reads != 3'h0))
    else $error("split read flag disagrees with destination reads");

endmodule : ict_timer

// file: ict_map.svh
// timing constants, mode codes and field positions for the instruction cycle timer
// assumes a 250 MHz core clock; all figures are microcode timings of the sequencer
//
// What this block does
// [RULE1] microcode runs on a fixed 267 ns cycle; times are cycles times 267 ns; pacing rounds each cycle up to 67 core clocks (268 ns)
// [RULE2] both modes autodecrement PC: take 534 ns and one read fewer
// [RULE3] write-only or read-modify-write destination mode 07 or 17: same saving
// [RULE4] read-only or RMW destination mode 47 issues three reads, one under fetch
// [RULE5] read-only or RMW destination mode 57 issues four reads, one under fetch
// [RULE6] subroutine call with PC as link register is one cycle faster
// [RULE7] sign-dependent instruction adds one cycle when the source operand is negative
// [RULE8] source-mode-adjusted instructions are one cycle shorter for nonzero source mode
// [RULE9] division adds one cycle when the quotient is even
// [RULE10] division adds 534 ns when overflow is detected
// [RULE11] division to PC, source not 47/57: add 1335 ns and one read
// [RULE12] shifts add one cycle per bit position shifted
// [RULE13] combined shift left adds one cycle when source bits 15:6 nonzero
// [RULE14] combined shift right saves one cycle for a single position
// [RULE15] multiply or shift to PC, source not 47/57: add 1068 ns, one read
// [RULE16] total is base contributions plus every applicable correction, added together
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

// ==========================================================
// clocking
`define ICT_UCYC_NS            267
`define ICT_CLK_NS             4
`define ICT_CLKS_PER_UCYC      ((`ICT_UCYC_NS + `ICT_CLK_NS - 1) / `ICT_CLK_NS)
`define ICT_CYC(ns)            ((ns) / `ICT_UCYC_NS)

// ==========================================================
// correction times
`define ICT_PCDEC_SAVE_NS      534
`define ICT_CALL_SAVE_NS       267
`define ICT_NEG_ADD_NS         267
`define ICT_SRCMODE_SAVE_NS    267
`define ICT_QEVEN_ADD_NS       267
`define ICT_DIVOVF_ADD_NS      534
`define ICT_DIVPC_ADD_NS       1335
`define ICT_SHIFT_ADD_NS       267
`define ICT_HIBITS_ADD_NS      267
`define ICT_ONESHIFT_SAVE_NS   267
`define ICT_MULPC_ADD_NS       1068

// ==========================================================
// mode/register codes and operand fields
`define ICT_MODE_07            6'h07
`define ICT_MODE_17            6'h0F
`define ICT_MODE_47            6'h27
`define ICT_MODE_57            6'h2F
`define ICT_PC_REG             3'h7
`define ICT_M47_READS          3'h3
`define ICT_M57_READS          3'h4
`define ICT_SIGN_BIT           15
`define ICT_HI_MSB             15
`define ICT_HI_LSB             6

`endif

// file: ict_pkg.sv
// types shared by the instruction cycle timer and its correction unit
// assumes ict_map.svh supplies all numeric constants
package ict_pkg;

  typedef enum logic [2:0] {
    ICT_OP_OTHER,
    ICT_OP_SUBROUTINE_CALL,
    ICT_OP_MUL,
    ICT_OP_DIV,
    ICT_OP_ASH,
    ICT_OP_ASHC
  } ict_op_t;

  typedef enum logic [1:0] {
    ICT_DST_NONE,
    ICT_DST_RO,
    ICT_DST_WO,
    ICT_DST_RMW
  } ict_dkind_t;

  typedef enum logic [1:0] {
    ICT_S_IDLE,
    ICT_S_CALC,
    ICT_S_RUN,
    ICT_S_DONE
  } ict_state_t;

  typedef struct packed {
    ict_op_t     op;
    ict_dkind_t  dst_kind;
    logic [5:0]  src_mr;
    logic [5:0]  dst_mr;
    logic        link_is_pc;
    logic [15:0] src_val;
    logic        shift_left;
    logic [5:0]  shift_cnt;
    logic        quot_even;
    logic        overflow;
    logic [7:0]  base_cyc;
    logic [3:0]  base_rd;
  } ict_req_t;

  typedef struct packed {
    logic [8:0]  cycles;
    logic [3:0]  reads;
    logic [17:0] time_ns;
    logic [2:0]  dst_reads;
    logic        split_read;
  } ict_res_t;

endpackage : ict_pkg

// file: ict_adjust.sv
// correction unit: signed cycle and read corrections for one instruction
// purely combinational; inputs are held stable by the sequencer while used
`timescale 1ns/10ps
`include "ict_map.svh"

module ict_adjust
  import ict_pkg::*;
(
  input  ict_req_t          req,
  output logic signed [7:0] delta_cyc,
  output logic signed [2:0] delta_rd,
  output logic [2:0]        dst_rd,
  output logic              split_rd
);

  localparam logic signed [7:0] PCDEC   = 8'(`ICT_CYC(`ICT_PCDEC_SAVE_NS));
  localparam logic signed [7:0] CALLS   = 8'(`ICT_CYC(`ICT_CALL_SAVE_NS));
  localparam logic signed [7:0] NEGA    = 8'(`ICT_CYC(`ICT_NEG_ADD_NS));
  localparam logic signed [7:0] SRCS    = 8'(`ICT_CYC(`ICT_SRCMODE_SAVE_NS));
  localparam logic signed [7:0] QEVA    = 8'(`ICT_CYC(`ICT_QEVEN_ADD_NS));
  localparam logic signed [7:0] OVFA    = 8'(`ICT_CYC(`ICT_DIVOVF_ADD_NS));
  localparam logic signed [7:0] DIVPCA  = 8'(`ICT_CYC(`ICT_DIVPC_ADD_NS));
  localparam logic signed [7:0] SHFA    = 8'(`ICT_CYC(`ICT_SHIFT_ADD_NS));
  localparam logic signed [7:0] HIA     = 8'(`ICT_CYC(`ICT_HIBITS_ADD_NS));
  localparam logic signed [7:0] ONES    = 8'(`ICT_CYC(`ICT_ONESHIFT_SAVE_NS));
  localparam logic signed [7:0] MULPCA  = 8'(`ICT_CYC(`ICT_MULPC_ADD_NS));

  // source deferred through PC-relative modes suppresses the PC-destination penalty
  function automatic logic src_pc_indirect(input logic [5:0] mr);
    src_pc_indirect = (mr == `ICT_MODE_47) || (mr == `ICT_MODE_57);
  endfunction : src_pc_indirect

  logic dst_is_pc;
  logic shifter;
  logic dst_reads_more;

  assign dst_is_pc      = (req.dst_mr[2:0] == `ICT_PC_REG);
  assign shifter        = (req.op == ICT_OP_ASH) || (req.op == ICT_OP_ASHC);
  assign dst_reads_more = (req.dst_kind == ICT_DST_RO) || (req.dst_kind == ICT_DST_RMW);

  always_comb begin
    delta_cyc = 8'sh00;
    delta_rd  = 3'sh0;
    dst_rd    = 3'h0;
    split_rd  = 1'b0;
    // the two saving cases are alternatives of one saving, never stacked
    if (((req.src_mr == `ICT_MODE_47) && (req.dst_mr == `ICT_MODE_47)) ||  // RULE2
        (((req.dst_kind == ICT_DST_WO) || (req.dst_kind == ICT_DST_RMW)) &&
         ((req.dst_mr == `ICT_MODE_07) || (req.dst_mr == `ICT_MODE_17)))) begin  // RULE3
      delta_cyc = delta_cyc - PCDEC;
      delta_rd  = delta_rd - 3'sh1;
    end
    if (dst_reads_more && (req.dst_mr == `ICT_MODE_47)) begin  // RULE4
      dst_rd   = `ICT_M47_READS;
      split_rd = 1'b1;
    end
    if (dst_reads_more && (req.dst_mr == `ICT_MODE_57)) begin  // RULE5
      dst_rd   = `ICT_M57_READS;
      split_rd = 1'b1;
    end
    if ((req.op == ICT_OP_SUBROUTINE_CALL) && req.link_is_pc) begin
      delta_cyc = delta_cyc - CALLS;  // RULE6
    end
    if ((req.op == ICT_OP_MUL) && req.src_val[`ICT_SIGN_BIT]) begin
      delta_cyc = delta_cyc + NEGA;  // RULE7
    end
    if (req.op == ICT_OP_DIV) begin
      if (req.src_mr[5:3] != 3'h0) begin
        delta_cyc = delta_cyc - SRCS;  // RULE8
      end
      if (req.quot_even) begin
        delta_cyc = delta_cyc + QEVA;  // RULE9
      end
      if (req.overflow) begin
        delta_cyc = delta_cyc + OVFA;  // RULE10
      end
      if (dst_is_pc && !src_pc_indirect(req.src_mr)) begin
        delta_cyc = delta_cyc + DIVPCA;  // RULE11
        delta_rd  = delta_rd + 3'sh1;
      end
    end
    if (shifter) begin
      delta_cyc = delta_cyc + SHFA * $signed({2'h0, req.shift_cnt});  // RULE12
    end
    if (req.op == ICT_OP_ASHC) begin
      if (req.shift_left && (req.src_val[`ICT_HI_MSB:`ICT_HI_LSB] != 10'h000)) begin
        delta_cyc = delta_cyc + HIA;  // RULE13
      end
      if (!req.shift_left && (req.shift_cnt == 6'h01)) begin
        delta_cyc = delta_cyc - ONES;  // RULE14
      end
    end
    if ((shifter || (req.op == ICT_OP_MUL)) && dst_is_pc && !src_pc_indirect(req.src_mr)) begin
      delta_cyc = delta_cyc + MULPCA;  // RULE15
      delta_rd  = delta_rd + 3'sh1;
    end
  end

endmodule : ict_adjust

// file: ict_req_source.sv
// requester model: presents one instruction descriptor at a time to the timer
// assumes the bench calls its tasks from a single process, at most one at a time
`timescale 1ns/10ps

module ict_req_source
  import ict_pkg::*;
(
  input  logic     core_clk,
  input  logic     req_ready,
  output ict_req_t req,
  output logic     req_valid
);

  // ==========================================================
  // idle state
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // ==========================================================
  // transfers
  // the descriptor is held until an edge sees ready; afterwards it is inverted
  // so that a late sample of a released bus cannot pass for the old value
  task automatic send(input ict_req_t d);
    int n;
    @(negedge core_clk);
    req_valid = 1'b1;
    req       = d;
    n         = 0;
    @(posedge core_clk);
    while (!req_ready && n < 5000) begin
      n++;
      @(posedge core_clk);
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    req       = ict_req_t'(~req);
  endtask : send

  // raise the strobe while the timer is busy; the timer must not queue it
  task automatic stray(input int n);
    @(negedge core_clk);
    req_valid = 1'b1;
    repeat (n) @(negedge core_clk);
    req_valid = 1'b0;
  endtask : stray

endmodule : ict_req_source

// file: ict_timer_bench.sv
// self-checking bench for the instruction cycle timer
// assumes ict_req_source drives the request side; inputs change on falling edges
`timescale 1ns/10ps
`include "ict_map.svh"

module ict_timer_bench import ict_pkg::*;;

  logic        core_clk;
  logic        rstn;
  logic        req_valid;
  ict_req_t    req;
  logic        req_ready;
  logic        busy;
  logic        ucyc_tick;
  logic        done;
  ict_res_t    res;
  ict_res_t    exp_q[$];
  ict_res_t    e;
  ict_req_t    d;
  logic [31:0] seed;
  logic [31:0] r;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc_n     = 0;
  int          acc_n     = 0;
  int          tick_n    = 0;
  int          tmo_n     = 0;
  int          drain_n   = 0;

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  ict_timer i_ict_timer (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .busy(busy), .ucyc_tick(ucyc_tick), .done(done), .res(res));

  ict_req_source i_ict_req_source (.core_clk(core_clk), .req_ready(req_ready), .req(req),
    .req_valid(req_valid));

  // ==========================================================
  // reference and helpers
  function automatic ict_res_t exp_of(input ict_req_t q);
    int       c;
    int       rd;
    logic     dpc;
    logic     s4757;
    ict_res_t x;
    c     = q.base_cyc;
    rd    = q.base_rd;
    dpc   = (q.dst_mr[2:0] == 3'h7);
    s4757 = (q.src_mr == 6'h27) || (q.src_mr == 6'h2F);
    // both savings are one saving, never taken twice
    if ((q.src_mr == 6'h27 && q.dst_mr == 6'h27) || (q.dst_kind inside {ICT_DST_WO, ICT_DST_RMW}
        && q.dst_mr inside {6'h07, 6'h0F})) begin
      c  -= 2;
      rd -= 1;
    end
    if (q.op == ICT_OP_SUBROUTINE_CALL && q.link_is_pc) c -= 1;
    if (q.op == ICT_OP_MUL && q.src_val[15]) c += 1;
    if (q.op == ICT_OP_DIV) begin
      if (q.src_mr[5:3] != 3'h0) c -= 1;
      if (q.quot_even) c += 1;
      if (q.overflow) c += 2;
      if (dpc && !s4757) begin
        c  += 5;
        rd += 1;
      end
    end
    if (q.op inside {ICT_OP_ASH, ICT_OP_ASHC}) c += q.shift_cnt;
    if (q.op == ICT_OP_ASHC && q.shift_left && q.src_val[15:6] != 10'h000) c += 1;
    if (q.op == ICT_OP_ASHC && !q.shift_left && q.shift_cnt == 6'h01) c -= 1;
    if (q.op inside {ICT_OP_MUL, ICT_OP_ASH, ICT_OP_ASHC} && dpc && !s4757) begin
      c  += 4;
      rd += 1;
    end
    if (c < 0) c = 0;
    if (rd < 0) rd = 0;
    x.cycles    = 9'(c);
    x.reads     = 4'(rd);
    x.time_ns   = 18'(c * `ICT_UCYC_NS);
    x.dst_reads = 3'h0;
    if (q.dst_kind inside {ICT_DST_RO, ICT_DST_RMW} && q.dst_mr == 6'h27) x.dst_reads = 3'h3;
    if (q.dst_kind inside {ICT_DST_RO, ICT_DST_RMW} && q.dst_mr == 6'h2F) x.dst_reads = 3'h4;
    x.split_read = (x.dst_reads != 3'h0);
    return x;
  endfunction : exp_of

  function automatic ict_req_t mk(input ict_op_t op, input ict_dkind_t dk, input logic [5:0] sm,
      input logic [5:0] dm, input logic [15:0] sv, input logic lft, input logic [5:0] cnt,
      input logic [2:0] fl);
    ict_req_t q;
    q = '{op, dk, sm, dm, fl[2], sv, lft, cnt, fl[1], fl[0], 8'h06, 4'h3};
    return q;
  endfunction : mk

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [5:0] pick(input logic [2:0] k, input logic [5:0] alt);
    case (k)
      3'h0:    return 6'h27;
      3'h1:    return 6'h2F;
      3'h2:    return 6'h07;
      3'h3:    return 6'h0F;
      default: return alt;
    endcase
  endfunction : pick

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic run(input ict_req_t q, input logic strayed);
    exp_q.push_back(exp_of(q));
    i_ict_req_source.send(q);
    if (strayed) i_ict_req_source.stray(3);
  endtask : run

  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // monitor: comb outputs seen here still hold their pre-edge values
  always @(posedge core_clk) begin
    cyc_n++;
    if (rstn) begin
      if (req_valid && req_ready) begin
        acc_n  = cyc_n;
        tick_n = 0;
      end
      if (ucyc_tick) tick_n++;
      if (done) begin
        if (exp_q.size() == 0) begin
          check(64'(done), 64'h0);
        end else begin
          e = exp_q.pop_front();
          check(64'(res), 64'(e));
          check(64'(cyc_n - acc_n), 64'(2 + `ICT_CLKS_PER_UCYC * e.cycles));
          check(64'(tick_n), 64'(e.cycles));
        end
      end
    end
  end

  // a hang is cut short well above the longest expected run
  always @(posedge core_clk) begin
    tmo_n++;
    if (tmo_n >= 100000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // stimulus
  initial begin
    rstn = 1'b0;
    seed = 32'h3396;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    check({busy, req_ready, 35'(res)}, {2'b01, 35'h0});
    for (int i = 0; i < 20; i++) begin
      case (i)
        0:  d = mk(ICT_OP_OTHER, ICT_DST_NONE, 6'h27, 6'h27, 16'h0, 1'b0, 6'h00, 3'h0);
        1:  d = mk(ICT_OP_OTHER, ICT_DST_WO, 6'h01, 6'h07, 16'h0, 1'b0, 6'h00, 3'h0);
        2:  d = mk(ICT_OP_OTHER, ICT_DST_RMW, 6'h01, 6'h0F, 16'h0, 1'b0, 6'h00, 3'h0);
        3:  d = mk(ICT_OP_OTHER, ICT_DST_RO, 6'h01, 6'h0F, 16'h0, 1'b0, 6'h00, 3'h0);
        4:  d = mk(ICT_OP_OTHER, ICT_DST_RO, 6'h01, 6'h27, 16'h0, 1'b0, 6'h00, 3'h0);
        5:  d = mk(ICT_OP_OTHER, ICT_DST_RMW, 6'h01, 6'h2F, 16'h0, 1'b0, 6'h00, 3'h0);
        6:  d = mk(ICT_OP_SUBROUTINE_CALL, ICT_DST_NONE, 6'h01, 6'h11, 16'h0, 1'b0, 6'h00,
                   3'h4);
        7:  d = mk(ICT_OP_MUL, ICT_DST_NONE, 6'h01, 6'h01, 16'h8000, 1'b0, 6'h00, 3'h0);
        8:  d = mk(ICT_OP_DIV, ICT_DST_NONE, 6'h10, 6'h01, 16'h0, 1'b0, 6'h00, 3'h0);
        9:  d = mk(ICT_OP_DIV, ICT_DST_NONE, 6'h00, 6'h01, 16'h0, 1'b0, 6'h00, 3'h3);
        10: d = mk(ICT_OP_DIV, ICT_DST_NONE, 6'h00, 6'h01, 16'h0, 1'b0, 6'h00, 3'h1);
        11: d = mk(ICT_OP_DIV, ICT_DST_NONE, 6'h00, 6'h07, 16'h0, 1'b0, 6'h00, 3'h0);
        12: d = mk(ICT_OP_DIV, ICT_DST_NONE, 6'h2F, 6'h37, 16'h0, 1'b0, 6'h00, 3'h0);
        13: d = mk(ICT_OP_ASH, ICT_DST_NONE, 6'h01, 6'h01, 16'h0, 1'b0, 6'h3F, 3'h0);
        14: d = mk(ICT_OP_ASHC, ICT_DST_NONE, 6'h01, 6'h01, 16'h0040, 1'b1, 6'h02, 3'h0);
        15: d = mk(ICT_OP_ASHC, ICT_DST_NONE, 6'h01, 6'h01, 16'h003F, 1'b1, 6'h02, 3'h0);
        16: d = mk(ICT_OP_ASHC, ICT_DST_NONE, 6'h01, 6'h01, 16'h0, 1'b0, 6'h01, 3'h0);
        17: d = mk(ICT_OP_MUL, ICT_DST_NONE, 6'h00, 6'h07, 16'h0, 1'b0, 6'h00, 3'h0);
        18: d = mk(ICT_OP_ASH, ICT_DST_NONE, 6'h27, 6'h17, 16'h0, 1'b0, 6'h01, 3'h0);
        default: begin
          d = mk(ICT_OP_OTHER, ICT_DST_NONE, 6'h27, 6'h27, 16'h0, 1'b0, 6'h00, 3'h0);
          d.base_cyc = 8'h00;
          d.base_rd  = 4'h0;
        end
      endcase
      run(d, i == 13);
    end
    // random descriptors, back to back, with no refused strobes
    for (int i = 0; i < 16; i++) begin
      r = xs();
      d = mk(ict_op_t'(r[2:0] % 6), ict_dkind_t'(r[4:3]), pick(r[7:5], r[21:16]),
             pick(r[10:8], r[27:22]), 16'(xs()), r[11], {3'h0, r[14:12]}, r[30:28]);
      d.base_cyc = {4'h0, r[15], r[31], r[13], r[12]};
      d.base_rd  = {1'b0, r[9:7]};
      run(d, 1'b0);
    end
    while (exp_q.size() != 0 && drain_n < 20000) begin
      drain_n++;
      @(posedge core_clk);
    end
    // a result still owed when the drain limit runs out counts as a miss
    if (exp_q.size() != 0) error_cnt++;
    repeat (4) @(posedge core_clk);
    complete_run();
  end

endmodule : ict_timer_bench
